// >>> tb/hca_allocator_properties.sv
// Checker for the allocator ports: APB answer timing and TDM output timing.
// Assumes bit_strobe pulses once per bit and frame_start marks bit 0.
`timescale 1ns/1ns
module hca_allocator_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic frame_start,
	input wire logic bit_strobe,
	input wire logic transmit_clock_enable_n,
	input wire logic receive_clock_enable_n,
	input wire logic outgoing_control_stream
);
	logic [7:0] slot_reg;
	logic synced_reg;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Slot of the bit that ends at each strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_reg <= 8'h00;
			synced_reg <= 1'b0;
		end else if (bit_strobe) begin
			slot_reg <= frame_start ? 8'h00 : slot_reg + 8'h01;
			synced_reg <= synced_reg | frame_start;
		end
	end
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held two cycles");
	a_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after access");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without ready or with data");
	a_reset_idle: assert property ($rose(presetn) |->
		transmit_clock_enable_n && receive_clock_enable_n && outgoing_control_stream && !pready)
		else $error("outputs not idle after reset");
	a_tx_hold: assert property (!$past(bit_strobe) |-> $stable(transmit_clock_enable_n))
		else $error("send enable moved between strobes");
	a_rx_hold: assert property (!$past(bit_strobe) |-> $stable(receive_clock_enable_n))
		else $error("receive enable moved between strobes");
	a_stream_hold: assert property (!$past(bit_strobe) |-> $stable(outgoing_control_stream))
		else $error("stream moved between strobes");
	a_tx_dregion: assert property (bit_strobe && synced_reg && !transmit_clock_enable_n |-> slot_reg[7])
		else $error("send enable outside D-channels");
	a_rx_dregion: assert property (bit_strobe && synced_reg && !receive_clock_enable_n |-> slot_reg[7])
		else $error("receive enable outside D-channels");
endmodule
bind hca_allocator hca_allocator_properties hca_chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.frame_start(frame_start), .bit_strobe(bit_strobe),
	.transmit_clock_enable_n(transmit_clock_enable_n),
	.receive_clock_enable_n(receive_clock_enable_n),
	.outgoing_control_stream(outgoing_control_stream));

// >>> tb/hca_allocator_tb.sv
// Testbench for the allocator: APB master, TDM timing, frame monitor.
// Assumes a bit strobe every second clock and 256 bits per frame.
`timescale 1ns/1ns
module hca_allocator_tb;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} hca_exp_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bit_strobe, frame_start, ph, ics;
	logic [7:0] paddr, slot_tb;
	logic [31:0] pwdata, prdata, seed;
	logic send_eop, recv_eop, fdi, tx_en_n, rx_en_n, ocs, send_req, recv_req;
	logic [7:0] cm [16];
	logic [7:0] inb [32];
	logic [255:0] in_bits, cexp, txm, rxm, sm, et, er;
	logic [1:0] bauds [3] = '{hca_pkg::BAUD_8K, hca_pkg::BAUD_16K, hca_pkg::BAUD_64K};
	logic [3:0] nbs [3] = '{hca_pkg::BITS_8K, hca_pkg::BITS_16K, hca_pkg::BITS_64K};
	hca_exp_t aq [$];
	hca_exp_t mx;
	logic [255:0] fq_tx [$];
	logic [255:0] fq_rx [$];
	int failures = 0, cmp_count = 0, i;
	event frame_ev;
	hca_allocator dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frame_start(frame_start), .bit_strobe(bit_strobe),
		.send_end_of_packet_strobe(send_eop), .receive_end_of_packet_strobe(recv_eop),
		.formatted_dchannel_input(fdi), .incoming_control_stream(ics), .hunt_found(1'b0),
		.hunt_channel(4'h0), .transmit_clock_enable_n(tx_en_n),
		.receive_clock_enable_n(rx_en_n), .outgoing_control_stream(ocs));
	hca_ctrl_model model_u (.pclk(pclk), .presetn(presetn), .bit_strobe(bit_strobe),
		.transmit_clock_enable_n(tx_en_n), .receive_clock_enable_n(rx_en_n),
		.send_req(send_req), .recv_req(recv_req), .send_end_of_packet_strobe(send_eop),
		.receive_end_of_packet_strobe(recv_eop), .formatted_dchannel_input(fdi));
	always #5 pclk = ~pclk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [255:0] mk(input int ch, input logic [3:0] nb);
		logic [255:0] v;
		v = '0;
		for (int b = 0; b < 8; b++) if (b < nb) v[(16 + ch) * 8 + b] = 1'b1;
		return v;
	endfunction
	task automatic stop_test();
		if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cmpf(input logic [255:0] g, input logic [255:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One APB transfer; its expected answer is queued first
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic e);
		int n;
		n = 0;
		aq.push_back('{d: d, m: m, e: e});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n == 20) failures++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Expect the enable masks of the next whole frame
	task automatic chk(input logic [255:0] t, input logic [255:0] r);
		@(frame_ev);
		fq_tx.push_back(t);
		fq_rx.push_back(r);
		@(frame_ev);
	endtask
	task automatic pulse_send();
		send_req <= 1'b1;
		@(posedge pclk);
		send_req <= 1'b0;
	endtask
	// Bit strobe, frame marker and incoming stream bits
	always @(posedge pclk) begin
		ph <= ~ph;
		bit_strobe <= ph;
		frame_start <= ph && slot_tb == 8'hFF;
		if (bit_strobe) begin
			slot_tb <= slot_tb + 8'h01;
			ics <= in_bits[slot_tb + 8'h01];
		end
	end
	// Monitor: APB answers, then frame masks at each frame end
	always @(posedge pclk) begin
		if (pready === 1'b1 && aq.size() > 0) begin
			mx = aq.pop_front();
			cmp32(prdata & mx.m, mx.d & mx.m);
			cmp32({31'h0, pslverr}, {31'h0, mx.e});
		end
		if (bit_strobe) begin
			txm[slot_tb] = ~tx_en_n;
			rxm[slot_tb] = ~rx_en_n;
			sm[slot_tb] = ocs;
			if (frame_start) begin
				if (fq_tx.size() > 0) begin
					et = fq_tx.pop_front();
					er = fq_rx.pop_front();
					cmpf(txm, et);
					cmpf(rxm, er);
					cmpf(sm, cexp & ~et);
				end
				->frame_ev;
			end
		end
	end
	initial begin
		repeat (40000) @(posedge pclk);
		failures++;
		stop_test();
	end
	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		send_req = 0; recv_req = 0; ph = 0; bit_strobe = 0; frame_start = 0; slot_tb = 0;
		ics = 1; cexp = '1; seed = 32'h54E71E46;
		for (i = 0; i < 32; i++) begin
			seed = lfsr(seed);
			inb[i] = seed[7:0];
		end
		for (i = 0; i < 256; i++) in_bits[i] = inb[i / 8][7 - i % 8];
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, hca_pkg::ADDR_STATUS_ONE, 32'h0, 32'h1F, 0);
		apb(0, 8'h20, 32'h0, 32'hFFFFFFFF, 1);
		apb(1, hca_pkg::ADDR_DATA_BASE, 32'h0, 32'h0, 1);
		for (i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			cm[i] = seed[7:0];
			apb(1, hca_pkg::ADDR_CONNECT_BASE + 8'(4 * i), {24'h0, cm[i]}, 32'h0, 0);
			apb(0, hca_pkg::ADDR_CONNECT_BASE + 8'(4 * i), {24'h0, cm[i]}, 32'hFF, 0);
		end
		for (i = 0; i < 128; i++) cexp[i] = cm[i / 8][7 - i % 8];
		for (i = 0; i < 3; i++) begin
			apb(1, hca_pkg::ADDR_CONTROL_ONE, {30'h0, bauds[i]}, 32'h0, 0);
			if (i == 0) begin
				apb(1, hca_pkg::ADDR_CONTROL_THREE, 32'h3, 32'h0, 0);
				apb(0, hca_pkg::ADDR_STATUS_ONE, 32'h11, 32'h1F, 0);
			end
			chk(mk(3, nbs[i]), '0);
		end
		apb(0, hca_pkg::ADDR_STATUS_FOUR, 32'h3, 32'hFF, 0);
		apb(1, hca_pkg::ADDR_CONTROL_THREE, 32'h7, 32'h0, 0);
		chk(mk(3, 8), '0);
		pulse_send();
		@(frame_ev);
		chk(mk(7, 8), '0);
		apb(0, hca_pkg::ADDR_STATUS_FOUR, 32'h7, 32'h0F, 0);
		apb(1, hca_pkg::ADDR_CONTROL_TWO, 32'h20, 32'h0, 0);
		chk('0, '0);
		apb(0, hca_pkg::ADDR_CONTROL_TWO, 32'h20, 32'h20, 0);
		apb(0, hca_pkg::ADDR_CONTROL_TWO, 32'h0, 32'h20, 0);
		// Go-ahead on channel 0 while sending there: send slot yields for five frames
		apb(1, hca_pkg::ADDR_CONTROL_THREE, 32'h0, 32'h0, 0);
		apb(1, hca_pkg::ADDR_CONTROL_TWO, 32'h80, 32'h0, 0);
		apb(0, hca_pkg::ADDR_STATUS_ONE, 32'h19, 32'h1F, 0);
		chk('0, '0);
		repeat (2) @(frame_ev);
		chk(mk(0, 8), '0);
		apb(0, hca_pkg::ADDR_STATUS_ONE, 32'h0, 32'h08, 0);
		pulse_send();
		apb(1, hca_pkg::ADDR_CONTROL_TWO, 32'h12, 32'h0, 0);
		apb(0, hca_pkg::ADDR_STATUS_ONE, 32'h06, 32'h0E, 0);
		chk('0, mk(2, 8));
		apb(1, hca_pkg::ADDR_CONTROL_TWO, 32'h15, 32'h0, 0);
		chk('0, mk(2, 8));
		recv_req <= 1'b1;
		@(posedge pclk);
		recv_req <= 1'b0;
		@(frame_ev);
		chk('0, mk(5, 8));
		for (i = 0; i < 16; i++) apb(0, hca_pkg::ADDR_DATA_BASE + 8'(4 * i), {24'h0, inb[i]}, 32'hFF, 0);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, hca_pkg::ADDR_STATUS_ONE, 32'h0, 32'h1F, 0);
		chk('0, '0);
		stop_test();
	end
endmodule

// >>> tb/hca_ctrl_model.sv
// Model of the shared HDLC controller: serial output and end strobes.
// Assumes the allocator enables are valid from one strobe to the next.
`timescale 1ns/1ns
module hca_ctrl_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic bit_strobe,
	input wire logic transmit_clock_enable_n,
	input wire logic receive_clock_enable_n,
	input wire logic send_req,
	input wire logic recv_req,
	output logic send_end_of_packet_strobe,
	output logic receive_end_of_packet_strobe,
	output logic formatted_dchannel_input
);
	logic [1:0] ts_reg;
	logic [1:0] rs_reg;
	// Data bits are zeros, the inverse of idle ones; receive end strobe lasts one bit, send end strobe one clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts_reg <= 2'h0;
			rs_reg <= 2'h0;
			send_end_of_packet_strobe <= 1'b0;
			receive_end_of_packet_strobe <= 1'b0;
			formatted_dchannel_input <= 1'b0;
		end else begin
			formatted_dchannel_input <= 1'b0;
			if (send_req) begin
				ts_reg <= 2'h1;
			end else if (ts_reg == 2'h1 && !transmit_clock_enable_n && !bit_strobe) begin
				ts_reg <= 2'h2;
				send_end_of_packet_strobe <= 1'b1;
			end else if (ts_reg == 2'h2 && bit_strobe) begin
				ts_reg <= 2'h0;
				send_end_of_packet_strobe <= 1'b0;
			end
			if (recv_req) begin
				rs_reg <= 2'h1;
			end else if (rs_reg == 2'h1 && !receive_clock_enable_n && bit_strobe) begin
				rs_reg <= 2'h2;
				receive_end_of_packet_strobe <= 1'b1;
			end else if (rs_reg == 2'h2 && bit_strobe) begin
				rs_reg <= 2'h0;
				receive_end_of_packet_strobe <= 1'b0;
			end
		end
	end
endmodule

// >>> verilog/hca_allocator.sv
// Shared link allocator: clock enables for one shared HDLC controller over
// 16 D-channels, packet activity tracking, go-ahead insertion and merging of
// D- and C-channel data onto the outgoing control stream.
// Assumes frame_start and bit_strobe are one-cycle pulses synchronous to pclk,
// bit_strobe one per bit, frame_start one per 256-bit frame; D-channels occupy stream channels 16..31.
`timescale 1ns/1ns
module hca_allocator (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frame_start,
	input wire logic bit_strobe,
	input wire logic send_end_of_packet_strobe,
	input wire logic receive_end_of_packet_strobe,
	input wire logic formatted_dchannel_input,
	input wire logic incoming_control_stream,
	input wire logic hunt_found,
	input wire logic [3:0] hunt_channel,
	output logic transmit_clock_enable_n,
	output logic receive_clock_enable_n,
	output logic outgoing_control_stream
);
	// Bits per frame for a baud code
	function automatic logic [3:0] baud_bits(input logic [1:0] code);
		case (code)
			hca_pkg::BAUD_16K: baud_bits = hca_pkg::BITS_16K;
			hca_pkg::BAUD_64K: baud_bits = hca_pkg::BITS_64K;
			default: baud_bits = hca_pkg::BITS_8K;
		endcase
	endfunction

	// True in the leading bits of D-channel ch (second half frame)
	function automatic logic in_window(input logic [7:0] slot, input logic [3:0] ch,
		input logic [3:0] nbits);
		in_window = slot[7] && (slot[6:3] == ch) && ({1'b0, slot[2:0]} < nbits);
	endfunction

	hca_pkg::hca_apb_req_t req;
	assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

	logic [7:0] connect_mem [hca_pkg::MEM_WORDS];
	logic [7:0] data_mem [hca_pkg::MEM_WORDS];

	logic [7:0] slot_reg, slot_next;
	logic [1:0] baud_reg, baud_next;
	logic [3:0] next_send_channel_reg, next_send_channel_next;
	logic send_pending_reg, send_pending_next;
	logic [3:0] present_send_channel_reg, present_send_channel_next;
	logic send_channel_taken_reg, send_channel_taken_next;
	logic sender_active_reg, sender_active_next;
	logic software_send_end_of_packet_reg, software_send_end_of_packet_next;
	logic [3:0] dedicated_receive_channel_reg, dedicated_receive_channel_next;
	logic dedicated_pending_reg, dedicated_pending_next;
	logic [3:0] dedicated_live_channel_reg, dedicated_live_channel_next;
	logic dedicated_receive_select_reg, dedicated_receive_select_next;
	logic [3:0] present_receive_channel_reg, present_receive_channel_next;
	logic receive_channel_taken_reg, receive_channel_taken_next;
	logic receiver_active_reg, receiver_active_next;
	logic restart_ga_reg, restart_ga_next;
	hca_pkg::hca_ga_state_t ga_state_reg, ga_state_next;
	logic [3:0] ga_index_reg, ga_index_next;
	logic tx_en_n_reg, tx_en_n_next;
	logic rx_en_n_reg, rx_en_n_next;
	logic out_bit_reg, out_bit_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;

	logic access, wr, rd;
	logic [3:0] nbits;
	logic ga_window, tx_window, tx_preempt;

	assign access = req.sel && req.enable && !pready_reg;
	assign wr = access && req.write;
	assign rd = access && !req.write;
	assign nbits = baud_bits(baud_reg);
	assign ga_window = (ga_state_reg == hca_pkg::HCA_GA_SEND)
		&& in_window(slot_reg, present_receive_channel_reg, hca_pkg::GO_AHEAD_BITS);
	// Go-ahead owns the send slot of its own channel only
	assign tx_preempt = (ga_state_reg == hca_pkg::HCA_GA_SEND)
		&& (present_send_channel_reg == present_receive_channel_reg);
	assign tx_window = sender_active_reg && !tx_preempt
		&& in_window(slot_reg, present_send_channel_reg, nbits);

	// Next-state logic for the register file, packet flags and TDM outputs
	always_comb begin
		logic [7:0] slot_adv;
		logic send_end;
		logic recv_end;
		logic ga_start;
		logic [3:0] rx_ch;
		slot_adv = slot_reg + 8'h01;
		send_end = 1'b0;
		recv_end = 1'b0;
		ga_start = 1'b0;
		rx_ch = hca_pkg::CHANNEL_RESET;
		slot_next = slot_reg;
		baud_next = baud_reg;
		next_send_channel_next = next_send_channel_reg;
		send_pending_next = send_pending_reg;
		present_send_channel_next = present_send_channel_reg;
		send_channel_taken_next = send_channel_taken_reg;
		sender_active_next = sender_active_reg;
		software_send_end_of_packet_next = software_send_end_of_packet_reg;
		dedicated_receive_channel_next = dedicated_receive_channel_reg;
		dedicated_pending_next = dedicated_pending_reg;
		dedicated_live_channel_next = dedicated_live_channel_reg;
		dedicated_receive_select_next = dedicated_receive_select_reg;
		present_receive_channel_next = present_receive_channel_reg;
		receive_channel_taken_next = receive_channel_taken_reg;
		receiver_active_next = receiver_active_reg;
		restart_ga_next = restart_ga_reg;
		ga_state_next = ga_state_reg;
		ga_index_next = ga_index_reg;
		tx_en_n_next = tx_en_n_reg;
		rx_en_n_next = rx_en_n_reg;
		out_bit_next = out_bit_reg;
		prdata_next = 32'h0000_0000;
		pready_next = access;
		pslverr_next = 1'b0;

		// Read answers and read side effects
		if (rd) begin
			case (req.addr)
				hca_pkg::ADDR_CONTROL_ONE: prdata_next = {30'h0, baud_reg};
				hca_pkg::ADDR_CONTROL_TWO: begin
					prdata_next = {24'h0, restart_ga_reg, 1'b0,
						software_send_end_of_packet_reg, dedicated_receive_select_reg,
						dedicated_receive_channel_reg};
					software_send_end_of_packet_next = 1'b0;
				end
				hca_pkg::ADDR_CONTROL_THREE: prdata_next = {28'h0, next_send_channel_reg};
				hca_pkg::ADDR_STATUS_ONE: begin
					prdata_next = 32'h0000_0000;
					prdata_next[hca_pkg::ST1_SEND_TAKEN] = send_channel_taken_reg;
					prdata_next[hca_pkg::ST1_RECV_TAKEN] = receive_channel_taken_reg
						|| dedicated_receive_select_reg;
					prdata_next[hca_pkg::ST1_RECV_ACTIVE] = receiver_active_reg
						|| dedicated_receive_select_reg;
					prdata_next[hca_pkg::ST1_GO_AHEAD] = !dedicated_receive_select_reg
						&& (ga_state_reg == hca_pkg::HCA_GA_SEND);
					prdata_next[hca_pkg::ST1_SEND_ACTIVE] = sender_active_reg;
				end
				hca_pkg::ADDR_STATUS_FOUR: begin
					prdata_next = {24'h0, present_receive_channel_reg,
						present_send_channel_reg};
					send_channel_taken_next = 1'b0;
					receive_channel_taken_next = 1'b0;
				end
				default: begin
					if (req.addr[7:6] == 2'h1) begin
						prdata_next = {24'h0, connect_mem[req.addr[5:2]]};
					end else if (req.addr[7:6] == 2'h2) begin
						prdata_next = {24'h0, data_mem[req.addr[5:2]]};
					end else begin
						pslverr_next = 1'b1;
					end
				end
			endcase
		end

		// Register writes
		if (wr) begin
			case (req.addr)
				hca_pkg::ADDR_CONTROL_ONE: baud_next = req.wdata[1:0];
				hca_pkg::ADDR_CONTROL_TWO: begin
					// Dedicated channel waits in its buffer until receiver idles
					dedicated_receive_channel_next = req.wdata[3:0];
					dedicated_pending_next = 1'b1;
					dedicated_receive_select_next = req.wdata[hca_pkg::CT2_DED_SEL];
					if (req.wdata[hca_pkg::CT2_SW_SEND_EOP]) begin
						software_send_end_of_packet_next = 1'b1;
						send_end = 1'b1;
					end
					recv_end = req.wdata[hca_pkg::CT2_SW_RECV_EOP];
					if (req.wdata[hca_pkg::CT2_RESTART_GA]) begin
						restart_ga_next = 1'b1;
					end
				end
				hca_pkg::ADDR_CONTROL_THREE: begin
					next_send_channel_next = req.wdata[3:0];
					send_pending_next = 1'b1;
				end
				hca_pkg::ADDR_STATUS_ONE, hca_pkg::ADDR_STATUS_FOUR: ;
				default: pslverr_next = !(req.addr[7:6] == 2'h1);
			endcase
		end

		// Controller end strobes sampled once per bit
		if (bit_strobe && send_end_of_packet_strobe) begin
			send_end = 1'b1;
		end
		if (bit_strobe && receive_end_of_packet_strobe) begin
			recv_end = 1'b1;
		end

		// Send packet start and end
		if (send_end) begin
			sender_active_next = 1'b0;
		end else if (send_pending_reg && !sender_active_reg) begin
			present_send_channel_next = next_send_channel_reg;
			send_channel_taken_next = 1'b1;
			sender_active_next = 1'b1;
			send_pending_next = wr && (req.addr == hca_pkg::ADDR_CONTROL_THREE);
		end

		// Receive packet start and end
		if (recv_end) begin
			receiver_active_next = 1'b0;
		end else if (dedicated_receive_select_reg) begin
			if (dedicated_pending_reg && !receiver_active_reg) begin
				receiver_active_next = 1'b1;
				dedicated_live_channel_next = dedicated_receive_channel_reg;
				dedicated_pending_next = wr && (req.addr == hca_pkg::ADDR_CONTROL_TWO);
			end
		end else if (hunt_found && !receiver_active_reg && !receive_channel_taken_reg) begin
			present_receive_channel_next = hunt_channel;
			receive_channel_taken_next = 1'b1;
			receiver_active_next = 1'b1;
			ga_start = 1'b1;
		end

		// Go-ahead sequencer, never in dedicated mode
		if (restart_ga_reg) begin
			ga_start = 1'b1;
			restart_ga_next = 1'b0;
		end
		case (ga_state_reg)
			hca_pkg::HCA_GA_IDLE: begin
				if (ga_start && !dedicated_receive_select_reg) begin
					ga_state_next = hca_pkg::HCA_GA_SEND;
					ga_index_next = 4'h0;
				end
			end
			hca_pkg::HCA_GA_SEND: begin
				if (dedicated_receive_select_reg) begin
					ga_state_next = hca_pkg::HCA_GA_IDLE;
				end else if (bit_strobe && ga_window) begin
					if (ga_index_reg == hca_pkg::GO_AHEAD_LAST) begin
						ga_state_next = hca_pkg::HCA_GA_IDLE;
					end
					ga_index_next = ga_index_reg + 4'h1;
				end
			end
			default: ga_state_next = hca_pkg::HCA_GA_IDLE;
		endcase

		// Advance the bit slot and drive the next bit's outputs
		if (bit_strobe) begin
			slot_next = frame_start ? hca_pkg::SLOT_RESET : slot_adv;
			tx_en_n_next = !(sender_active_next && !tx_preempt
				&& in_window(slot_next, present_send_channel_next, nbits));
			// Dedicated mode follows the live copy, not the written buffer
			rx_ch = dedicated_receive_select_next ? dedicated_live_channel_next
				: present_receive_channel_next;
			rx_en_n_next = !(receiver_active_next
				&& in_window(slot_next, rx_ch, nbits));
			if (!slot_next[7]) begin
				out_bit_next = connect_mem[slot_next[6:3]][3'h7 - slot_next[2:0]];
			end else if ((ga_state_next == hca_pkg::HCA_GA_SEND)
				&& in_window(slot_next, present_receive_channel_reg, hca_pkg::GO_AHEAD_BITS)) begin
				out_bit_next = hca_pkg::GO_AHEAD_PATTERN[4'h8 - ga_index_next];
			end else if (!tx_en_n_next) begin
				out_bit_next = formatted_dchannel_input;
			end else begin
				out_bit_next = 1'b1;
			end
		end
	end

	// Connect memory writes and incoming C-channel capture
	always_ff @(posedge pclk) begin
		if (wr && (req.addr[7:6] == 2'h1)) begin
			connect_mem[req.addr[5:2]] <= req.wdata[7:0];
		end
		if (bit_strobe && !slot_reg[7]) begin
			data_mem[slot_reg[6:3]][3'h7 - slot_reg[2:0]] <= incoming_control_stream;
		end
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_reg <= hca_pkg::SLOT_RESET;
			baud_reg <= hca_pkg::BAUD_RESET;
			next_send_channel_reg <= hca_pkg::CHANNEL_RESET;
			send_pending_reg <= 1'b0;
			present_send_channel_reg <= hca_pkg::CHANNEL_RESET;
			send_channel_taken_reg <= 1'b0;
			sender_active_reg <= 1'b0;
			software_send_end_of_packet_reg <= 1'b0;
			dedicated_receive_channel_reg <= hca_pkg::CHANNEL_RESET;
			dedicated_pending_reg <= 1'b0;
			dedicated_live_channel_reg <= hca_pkg::CHANNEL_RESET;
			dedicated_receive_select_reg <= 1'b0;
			present_receive_channel_reg <= hca_pkg::CHANNEL_RESET;
			receive_channel_taken_reg <= 1'b0;
			receiver_active_reg <= 1'b0;
			restart_ga_reg <= 1'b0;
			ga_state_reg <= hca_pkg::HCA_GA_IDLE;
			ga_index_reg <= 4'h0;
			tx_en_n_reg <= 1'b1;
			rx_en_n_reg <= 1'b1;
			out_bit_reg <= 1'b1;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			slot_reg <= slot_next;
			baud_reg <= baud_next;
			next_send_channel_reg <= next_send_channel_next;
			send_pending_reg <= send_pending_next;
			present_send_channel_reg <= present_send_channel_next;
			send_channel_taken_reg <= send_channel_taken_next;
			sender_active_reg <= sender_active_next;
			software_send_end_of_packet_reg <= software_send_end_of_packet_next;
			dedicated_receive_channel_reg <= dedicated_receive_channel_next;
			dedicated_pending_reg <= dedicated_pending_next;
			dedicated_live_channel_reg <= dedicated_live_channel_next;
			dedicated_receive_select_reg <= dedicated_receive_select_next;
			present_receive_channel_reg <= present_receive_channel_next;
			receive_channel_taken_reg <= receive_channel_taken_next;
			receiver_active_reg <= receiver_active_next;
			restart_ga_reg <= restart_ga_next;
			ga_state_reg <= ga_state_next;
			ga_index_reg <= ga_index_next;
			tx_en_n_reg <= tx_en_n_next;
			rx_en_n_reg <= rx_en_n_next;
			out_bit_reg <= out_bit_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign transmit_clock_enable_n = tx_en_n_reg;
	assign receive_clock_enable_n = rx_en_n_reg;
	assign outgoing_control_stream = out_bit_reg;
endmodule

// >>> verilog/hca_pkg.sv
// Package for the shared link allocator: register map, field layout,
// reset values, go-ahead pattern and the bus carrier types.
// Assumes a 32-bit APB slave with word-aligned registers.
package hca_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
	localparam logic [7:0] ADDR_CONTROL_TWO = 8'h04;
	localparam logic [7:0] ADDR_CONTROL_THREE = 8'h08;
	localparam logic [7:0] ADDR_STATUS_ONE = 8'h0C;
	localparam logic [7:0] ADDR_STATUS_FOUR = 8'h10;
	localparam logic [7:0] ADDR_CONNECT_BASE = 8'h40;
	localparam logic [7:0] ADDR_DATA_BASE = 8'h80;
	// Control two field positions
	localparam int CT2_DED_CH_LSB = 0;
	localparam int CT2_DED_SEL = 4;
	localparam int CT2_SW_SEND_EOP = 5;
	localparam int CT2_SW_RECV_EOP = 6;
	localparam int CT2_RESTART_GA = 7;
	// Status one field positions
	localparam int ST1_SEND_TAKEN = 0;
	localparam int ST1_RECV_TAKEN = 1;
	localparam int ST1_RECV_ACTIVE = 2;
	localparam int ST1_GO_AHEAD = 3;
	localparam int ST1_SEND_ACTIVE = 4;
	// Status four field positions
	localparam int ST4_SEND_CH_LSB = 0;
	localparam int ST4_RECV_CH_LSB = 4;
	// Baud codes and enabled bits per frame
	localparam logic [1:0] BAUD_8K = 2'h0;
	localparam logic [1:0] BAUD_16K = 2'h1;
	localparam logic [1:0] BAUD_64K = 2'h2;
	localparam logic [3:0] BITS_8K = 4'h1;
	localparam logic [3:0] BITS_16K = 4'h2;
	localparam logic [3:0] BITS_64K = 4'h8;
	// Go-ahead pattern, sent most significant bit first
	localparam logic [8:0] GO_AHEAD_PATTERN = 9'h0FE;
	localparam logic [3:0] GO_AHEAD_LAST = 4'h8;
	localparam logic [3:0] GO_AHEAD_BITS = 4'h2;
	// Reset values
	localparam logic [1:0] BAUD_RESET = 2'h0;
	localparam logic [3:0] CHANNEL_RESET = 4'h0;
	localparam logic [7:0] SLOT_RESET = 8'h00;
	localparam int MEM_WORDS = 16;

	typedef enum logic [0:0] {
		HCA_GA_IDLE = 1'b0,
		HCA_GA_SEND = 1'b1
	} hca_ga_state_t;

	// One APB request as seen by the slave
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} hca_apb_req_t;
endpackage
